// *** design/emb_bus.sv ***
/*
 External memory bus master: a request FIFO feeding a two-phase cycle engine
 that drives the multiplexed address/data port, high address and strobes.
 Assumes requests and pins synchronous to CLK_I, external pull-ups on the
 strobes, and a pad layer that resolves each pin from its output enable.
*/
// Functional notes
// - Every memory cycle is an address phase followed by a data phase.
// - Address is driven when address strobe falls, valid when it rises.
// - High address stays stable from one address phase to the next.
// - Read: data port floats in data phase; data sampled at strobe rise.
// - Write: data driven from data strobe fall, held until next address.
// - Data strobe goes low in data phase only for external accesses.
// - Address strobe is low in each external address phase; its rise marks valid.
// - Strobes and read/write float on bus acknowledge or float bit.
// - Under reset strobes and read/write stay high, pulled up.
// - Read/write is high for reads, low for writes.
// - Read/write is set at cycle start and kept until next cycle.
// - Top address bit picks upper or lower block; lower uses second strobe in dual strobe mode.
// - Second strobe stays high whenever internal memory is addressed.
// - Second strobe reaches its pin only when its alternate function is on.
// - With wait enabled, each low wait sample stretches the current phase.
// - Dual strobe mode: lower block uses second strobe, primary stays high.
// - Per-block 2-bit stretch adds 0..3 address phase cycles; lower resets 3.
`include "emb_consts.svh"

module emb_fifo #(
    parameter int W = `EMB_REQ_W,
    parameter int D = `EMB_FIFO_DEPTH
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    output logic              out_valid_o,
    output logic [W-1:0]      out_data_o,
    input  wire logic         out_ready_i
);
    localparam int AW = $clog2(D);

    if (D < 2 || (D & (D - 1)) != 0) begin : g_bad_depth
        $error("emb_fifo depth must be a power of two, at least 2");
    end

    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    logic [AW:0]   cnt_nxt;
    logic          rdy_r;
    wire           push = in_valid_i && rdy_r;
    wire           pop  = out_valid_o && out_ready_i;

    assign in_ready_o  = rdy_r;
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o  = mem[rp_r];

    always_comb begin
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + (AW + 1)'(1);
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - (AW + 1)'(1);
        end
    end

    // Ready is registered so back-pressure reaches the source from a flop
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
            rdy_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            rdy_r <= (cnt_nxt != (AW + 1)'(D));
            if (push) begin
                wp_r <= wp_r + AW'(1);
            end
            if (pop) begin
                rp_r <= rp_r + AW'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wp_r] <= in_data_i;
        end
    end
endmodule : emb_fifo

module emb_bus #(
    parameter int FIFO_DEPTH = `EMB_FIFO_DEPTH
) (
    input  wire logic                   CLK_I,
    input  wire logic                   NRST_I,
    input  wire logic                   REQ_VALID_I,
    output logic                        REQ_READY_O,
    input  wire logic [`EMB_ADDR_W-1:0] REQ_ADDR_I,
    input  wire logic                   REQ_WRITE_I,
    input  wire logic                   REQ_EXT_I,
    input  wire logic [`EMB_AD_W-1:0]   REQ_WDATA_I,
    output logic                        RD_VALID_O,
    output logic [`EMB_AD_W-1:0]        RD_DATA_O,
    input  wire logic                   BUS_ACK_I,
    input  wire logic                   BUS_FLOAT_BIT_I,
    input  wire logic                   EXT_WAIT_ENABLE_I,
    input  wire logic                   DUAL_STROBE_ENABLE_I,
    input  wire logic                   LOWER_STROBE_AF_I,
    input  wire logic                   CFG_WE_I,
    input  wire logic [1:0]             LOWER_STROBE_STRETCH_I,
    input  wire logic [1:0]             UPPER_STROBE_STRETCH_I,
    output logic [1:0]                  LOWER_STROBE_STRETCH_O,
    output logic [1:0]                  UPPER_STROBE_STRETCH_O,
    input  wire logic                   WAIT_N_I,
    input  wire logic [`EMB_AD_W-1:0]   AD_I,
    output logic [`EMB_AD_W-1:0]        AD_O,
    output logic                        AD_OE_N_O,
    output logic [`EMB_HI_W-1:0]        HIGH_ADDR_O,
    output logic                        ADDR_STROBE_N_O,
    output logic                        DATA_STROBE_N_O,
    output logic                        LOWER_BLOCK_STROBE_N_O,
    output logic                        RW_O,
    output logic                        CTL_OE_N_O,
    output logic                        LOWER_BLOCK_OE_N_O
);
    if (FIFO_DEPTH < 2) begin : g_bad_depth
        $error("emb_bus needs a request FIFO of at least two words");
    end

    logic [`EMB_REQ_W-1:0] head;
    logic                  head_valid;
    logic                  fifo_ready;
    logic                  start;
    emb_pkg::emb_state_e   state_r;
    emb_pkg::emb_state_e   state_nxt;
    logic [1:0]            cnt_r;
    logic [1:0]            cnt_nxt;
    logic [`EMB_REQ_W-1:0] cur_r;
    logic [1:0]            lstr_r;
    logic [1:0]            ustr_r;

    emb_fifo #(.W(`EMB_REQ_W), .D(FIFO_DEPTH)) u_fifo (
        .clk_i       (CLK_I),
        .rst_n_i     (NRST_I),
        .in_valid_i  (REQ_VALID_I),
        .in_data_i   ({REQ_EXT_I, REQ_WRITE_I, REQ_WDATA_I, REQ_ADDR_I}),
        .in_ready_o  (fifo_ready),
        .out_valid_o (head_valid),
        .out_data_o  (head),
        .out_ready_i (start)
    );
    assign REQ_READY_O = fifo_ready;

    // Decode of the current and next request
    wire wait_act  = EXT_WAIT_ENABLE_I && !WAIT_N_I;
    wire t1_done   = (state_r == emb_pkg::ST_T1) && (cnt_r == 2'h0) && !wait_act;
    wire t2_done   = (state_r == emb_pkg::ST_T2) && !wait_act;
    // No new cycle is begun while the bus is handed to another master
    assign start   = head_valid && !BUS_ACK_I &&
                     ((state_r == emb_pkg::ST_IDLE) || t2_done);
    wire [`EMB_REQ_W-1:0] cur_nxt = start ? head : cur_r;
    wire       nx_ext   = cur_nxt[`EMB_EXT_BIT];
    wire       nx_wr    = cur_nxt[`EMB_WR_BIT];
    wire       nx_upper = cur_nxt[`EMB_TOP_BIT];
    wire       use_ds2  = DUAL_STROBE_ENABLE_I && !nx_upper;
    wire [1:0] head_str = head[`EMB_TOP_BIT] ? ustr_r : lstr_r;
    wire       cur_ext  = cur_r[`EMB_EXT_BIT];
    wire       cur_wr   = cur_r[`EMB_WR_BIT];
    wire       enter_t2 = t1_done;
    wire       rd_done  = t2_done && cur_ext && !cur_wr;
    wire       float_nx = BUS_ACK_I || BUS_FLOAT_BIT_I;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            emb_pkg::ST_IDLE: begin
                if (start) begin
                    state_nxt = emb_pkg::ST_T1;
                    cnt_nxt   = head_str;
                end
            end
            emb_pkg::ST_T1: begin
                // A low wait sample freezes the count, so it adds a cycle
                // even in the middle of a programmed stretch
                if (wait_act) begin
                    cnt_nxt = cnt_r;
                end else if (cnt_r != 2'h0) begin
                    cnt_nxt = cnt_r - 2'h1;
                end else begin
                    state_nxt = emb_pkg::ST_T2;
                end
            end
            emb_pkg::ST_T2: begin
                if (start) begin
                    state_nxt = emb_pkg::ST_T1;
                    cnt_nxt   = head_str;
                end else if (t2_done) begin
                    state_nxt = emb_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = emb_pkg::ST_IDLE;
                cnt_nxt   = 2'h0;
            end
        endcase
    end

    // Strobe levels follow the next state so that each pin is a flop output
    wire as_nxt  = !((state_nxt == emb_pkg::ST_T1) && nx_ext);
    wire t2_ext  = (state_nxt == emb_pkg::ST_T2) && nx_ext;
    wire ds_nxt  = !(t2_ext && !use_ds2);
    wire ds2_nxt = !(t2_ext && use_ds2);

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            state_r <= emb_pkg::ST_IDLE;
            cnt_r   <= 2'h0;
            cur_r   <= '0;
            lstr_r  <= `EMB_LSTR_RST;
            ustr_r  <= `EMB_USTR_RST;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            cur_r   <= cur_nxt;
            if (CFG_WE_I) begin
                lstr_r <= LOWER_STROBE_STRETCH_I;
                ustr_r <= UPPER_STROBE_STRETCH_I;
            end
        end
    end

    // Strobes held high and released to the pull-ups while in reset
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            ADDR_STROBE_N_O        <= 1'b1;
            DATA_STROBE_N_O        <= 1'b1;
            LOWER_BLOCK_STROBE_N_O <= 1'b1;
            CTL_OE_N_O             <= 1'b1;
            LOWER_BLOCK_OE_N_O     <= 1'b1;
        end else begin
            ADDR_STROBE_N_O        <= as_nxt;
            DATA_STROBE_N_O        <= ds_nxt;
            LOWER_BLOCK_STROBE_N_O <= ds2_nxt;
            CTL_OE_N_O             <= float_nx;
            LOWER_BLOCK_OE_N_O     <= float_nx || !LOWER_STROBE_AF_I;
        end
    end

    // Address, direction and data change only at a cycle start or T1 exit,
    // which keeps them frozen through every stretch cycle
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            RW_O        <= `EMB_RW_READ;
            HIGH_ADDR_O <= '0;
            AD_O        <= `EMB_AD_IDLE;
            AD_OE_N_O   <= 1'b1;
        end else if (start && nx_ext) begin
            RW_O        <= nx_wr ? `EMB_RW_WRITE : `EMB_RW_READ;
            HIGH_ADDR_O <= cur_nxt[`EMB_TOP_BIT:`EMB_HI_LSB];
            AD_O        <= cur_nxt[`EMB_AD_W-1:0];
            AD_OE_N_O   <= 1'b0;
        end else if (enter_t2 && cur_ext) begin
            AD_O        <= cur_wr ? cur_r[`EMB_WR_BIT-1:`EMB_WD_LSB] : AD_O;
            AD_OE_N_O   <= !cur_wr;
        end
    end

    // Read data taken on the edge where the data strobe rises
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            RD_VALID_O <= 1'b0;
            RD_DATA_O  <= '0;
        end else begin
            RD_VALID_O <= rd_done;
            if (rd_done) begin
                RD_DATA_O <= AD_I;
            end
        end
    end

    assign LOWER_STROBE_STRETCH_O = lstr_r;
    assign UPPER_STROBE_STRETCH_O = ustr_r;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);

    sequence s_long_t1;
        $fell(ADDR_STROBE_N_O) && (cnt_r == 2'h3);
    endsequence
    sequence s_read_end;
        (state_r == emb_pkg::ST_T2) && cur_ext && !cur_wr && !wait_act;
    endsequence
    sequence s_t1_exit;
        (state_r == emb_pkg::ST_T1) && (cnt_r == 2'h0) && !wait_act;
    endsequence
    sequence s_t1_wait;
        (state_r == emb_pkg::ST_T1) && wait_act;
    endsequence

    phase_order_a: assert property (s_t1_exit |=> state_r == emb_pkg::ST_T2)
        else $error("address phase not followed by data phase");
    addr_stable_a: assert property ((state_r != emb_pkg::ST_IDLE) && !start
            |=> $stable(HIGH_ADDR_O) && $stable(RW_O))
        else $error("address or direction moved inside a cycle");
    read_float_a: assert property ((state_r == emb_pkg::ST_T2) && cur_ext && !cur_wr
            |-> AD_OE_N_O)
        else $error("data port driven during read data phase");
    read_take_a: assert property (s_read_end |=> RD_VALID_O &&
            RD_DATA_O == $past(AD_I))
        else $error("read data not captured at strobe rise");
    write_data_a: assert property ((state_r == emb_pkg::ST_T2) && cur_ext && cur_wr
            |-> !AD_OE_N_O && AD_O == cur_r[`EMB_WR_BIT-1:`EMB_WD_LSB] && !RW_O)
        else $error("write data not on port in data phase");
    internal_quiet_a: assert property (!cur_ext
            |-> DATA_STROBE_N_O && LOWER_BLOCK_STROBE_N_O && ADDR_STROBE_N_O)
        else $error("strobe toggled on internal access");
    as_phase_a: assert property (!ADDR_STROBE_N_O |-> state_r == emb_pkg::ST_T1)
        else $error("address strobe low outside address phase");
    float_pins_a: assert property (float_nx |=> CTL_OE_N_O && LOWER_BLOCK_OE_N_O)
        else $error("control pins driven while floated");
    dual_block_a: assert property (!LOWER_BLOCK_STROBE_N_O
            |-> DATA_STROBE_N_O && !HIGH_ADDR_O[`EMB_HI_W-1])
        else $error("second strobe on wrong block");
    stretch_len_a: assert property (s_long_t1 |-> !ADDR_STROBE_N_O [*4])
        else $error("address strobe stretch too short");
    wait_hold_a: assert property ((state_r == emb_pkg::ST_T2) && wait_act
            |=> (state_r == emb_pkg::ST_T2) && $stable(AD_O))
        else $error("wait did not stretch data phase");
    // A wait in the address phase holds the stretch count where it is
    wait_t1_a: assert property (s_t1_wait |=> (state_r == emb_pkg::ST_T1) &&
            (cnt_r == $past(cnt_r)) && $stable(AD_O))
        else $error("wait did not stretch address phase");
    // Stretch cycles must not disturb what the memory is latching
    stretch_hold_a: assert property ((state_r == emb_pkg::ST_T1) &&
            (cnt_r != 2'h0 || wait_act)
            |=> $stable(AD_O) && $stable(AD_OE_N_O) && $stable(HIGH_ADDR_O))
        else $error("address moved during address phase stretch");
endmodule : emb_bus

// *** inc/emb_consts.svh ***
/*
 Constants of the external memory bus block: widths, field positions of a
 queued request word, reset values and pin levels.
 Assumes inclusion by bare name from the design file.
*/
`ifndef EMB_CONSTS_SVH
`define EMB_CONSTS_SVH
`define EMB_ADDR_W      22
`define EMB_AD_W        8
`define EMB_HI_LSB      8
`define EMB_HI_W        14
`define EMB_TOP_BIT     21
`define EMB_WD_LSB      22
`define EMB_WR_BIT      30
`define EMB_EXT_BIT     31
`define EMB_REQ_W       32
`define EMB_FIFO_DEPTH  8
`define EMB_LSTR_RST    2'h3
`define EMB_USTR_RST    2'h3
`define EMB_RW_READ     1'h1
`define EMB_RW_WRITE    1'h0
`define EMB_AD_IDLE     8'hFF
`endif

// *** inc/emb_pkg.sv ***
/*
 Types of the external memory bus block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package emb_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_T1   = 3'h2,
        ST_T2   = 3'h4
    } emb_state_e;
endpackage : emb_pkg

// *** tb/emb_mem_model.sv ***
/*
 Behavioural external ROM/RAM on the multiplexed address/data bus.
 Assumes the bus master's registered pins, all on one clock.
*/
module emb_mem_model (
    input  wire logic        clk_i,
    input  wire logic        slow_i,
    input  wire logic [7:0]  ad_o_i,
    input  wire logic [13:0] hi_i,
    input  wire logic        as_n_i,
    input  wire logic        ds_n_i,
    input  wire logic        ds2_n_i,
    input  wire logic        rw_i,
    output logic [7:0]       ad_i_o,
    output logic             wait_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  mem [logic [21:0]];
    logic [21:0] addr_r = 22'h000000;
    logic [7:0]  last_r = 8'h00;
    logic [7:0]  rd = 8'h00;
    logic        hold_r = 1'b0;
    logic        hold_a_r = 1'b0;
    wire         sel = !ds_n_i || !ds2_n_i;
    wire  [21:0] a_nxt = !as_n_i ? {hi_i, ad_o_i} : addr_r;
    // Released port shows the inverse of its last value
    assign ad_i_o = (sel && rw_i) ? rd : ~last_r;
    // One low wait sample per strobe when slow, in both phases
    assign wait_n_o = !(slow_i && ((sel && !hold_r) || (!as_n_i && !hold_a_r)));
    always @(posedge clk_i) begin
        last_r <= ad_i_o;
        hold_r <= sel;
        hold_a_r <= !as_n_i;
        addr_r <= a_nxt;
        if (sel && !rw_i) mem[addr_r] = ad_o_i;
        // Unwritten places answer a pattern of their address; looked up after
        // the write so that a read right behind a write sees the new byte
        rd <= mem.exists(a_nxt) ? mem[a_nxt] : a_nxt[7:0] ^ 8'hA5;
    end
endmodule : emb_mem_model

// *** tb/emb_bus_tb.sv ***
/*
 Self-checking bench of the external memory bus master.
 Assumes the memory model on the far side; all control bits are plain ports.
*/
module emb_bus_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [21:0] a;
        logic        dual;
        logic [1:0]  ls;
        logic [1:0]  us;
        logic [7:0]  d;
    } emb_row_s;
    emb_row_s rows [4] = '{
        '{22'h000012, 1'b0, 2'h0, 2'h0, 8'h3C}, '{22'h200034, 1'b1, 2'h1, 2'h2, 8'hC3},
        '{22'h0ABC56, 1'b1, 2'h3, 2'h0, 8'h5A}, '{22'h3FFFFF, 1'b0, 2'h2, 2'h3, 8'hFF}};
    logic CLK_I, NRST_I = 0, REQ_VALID_I = 0, REQ_WRITE_I = 0, REQ_EXT_I = 0;
    logic BUS_ACK_I = 0, BUS_FLOAT_BIT_I = 0, EXT_WAIT_ENABLE_I = 0;
    logic DUAL_STROBE_ENABLE_I = 0, LOWER_STROBE_AF_I = 1, CFG_WE_I = 0, slow = 0;
    logic [21:0] REQ_ADDR_I = 0;
    logic [7:0]  REQ_WDATA_I = 0, AD_I, AD_O, RD_DATA_O;
    logic [1:0]  LSI = 0, USI = 0, LSO, USO;
    logic [13:0] HIGH_ADDR_O, ds_hi;
    logic REQ_READY_O, RD_VALID_O, WAIT_N_I, AD_OE_N_O, ADDR_STROBE_N_O, DATA_STROBE_N_O;
    logic LOWER_BLOCK_STROBE_N_O, RW_O, CTL_OE_N_O, LOWER_BLOCK_OE_N_O;
    logic saw_ds = 0, saw_ds2 = 0, ds_rw, ds_oe, quiet;
    int as_cnt = 0, ds_cnt = 0, as_len = 0, ds_len = 0, err_count = 0, samples_checked = 0;
    wire strb = !DATA_STROBE_N_O || !LOWER_BLOCK_STROBE_N_O;
    emb_bus u_dut (.CLK_I(CLK_I), .NRST_I(NRST_I), .REQ_VALID_I(REQ_VALID_I),
        .REQ_READY_O(REQ_READY_O), .REQ_ADDR_I(REQ_ADDR_I), .REQ_WRITE_I(REQ_WRITE_I),
        .REQ_EXT_I(REQ_EXT_I), .REQ_WDATA_I(REQ_WDATA_I), .RD_VALID_O(RD_VALID_O),
        .RD_DATA_O(RD_DATA_O), .BUS_ACK_I(BUS_ACK_I), .BUS_FLOAT_BIT_I(BUS_FLOAT_BIT_I),
        .EXT_WAIT_ENABLE_I(EXT_WAIT_ENABLE_I), .DUAL_STROBE_ENABLE_I(DUAL_STROBE_ENABLE_I),
        .LOWER_STROBE_AF_I(LOWER_STROBE_AF_I), .CFG_WE_I(CFG_WE_I),
        .LOWER_STROBE_STRETCH_I(LSI), .UPPER_STROBE_STRETCH_I(USI),
        .LOWER_STROBE_STRETCH_O(LSO), .UPPER_STROBE_STRETCH_O(USO), .WAIT_N_I(WAIT_N_I),
        .AD_I(AD_I), .AD_O(AD_O), .AD_OE_N_O(AD_OE_N_O), .HIGH_ADDR_O(HIGH_ADDR_O),
        .ADDR_STROBE_N_O(ADDR_STROBE_N_O), .DATA_STROBE_N_O(DATA_STROBE_N_O),
        .LOWER_BLOCK_STROBE_N_O(LOWER_BLOCK_STROBE_N_O), .RW_O(RW_O),
        .CTL_OE_N_O(CTL_OE_N_O), .LOWER_BLOCK_OE_N_O(LOWER_BLOCK_OE_N_O));
    emb_mem_model u_mem (.clk_i(CLK_I), .slow_i(slow), .ad_o_i(AD_O), .hi_i(HIGH_ADDR_O),
        .as_n_i(ADDR_STROBE_N_O), .ds_n_i(DATA_STROBE_N_O),
        .ds2_n_i(LOWER_BLOCK_STROBE_N_O), .rw_i(RW_O), .ad_i_o(AD_I), .wait_n_o(WAIT_N_I));
    initial begin
        CLK_I = 0;
        forever #5 CLK_I = ~CLK_I;
    end
    // Strobe lengths and what the data phase showed, per cycle
    always @(posedge CLK_I) begin
        as_cnt <= ADDR_STROBE_N_O ? 0 : as_cnt + 1;
        ds_cnt <= strb ? ds_cnt + 1 : 0;
        if (ADDR_STROBE_N_O && as_cnt != 0) as_len <= as_cnt;
        if (!strb && ds_cnt != 0) ds_len <= ds_cnt;
        if (!ADDR_STROBE_N_O && as_cnt == 0) begin
            saw_ds <= 1'b0;
            saw_ds2 <= 1'b0;
        end
        if (strb) begin
            saw_ds <= saw_ds | !DATA_STROBE_N_O;
            saw_ds2 <= saw_ds2 | !LOWER_BLOCK_STROBE_N_O;
            ds_rw <= RW_O;
            ds_oe <= AD_OE_N_O;
            ds_hi <= HIGH_ADDR_O;
        end
    end
    task automatic close_out;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    task automatic check(input bit ok, input string msg);
        samples_checked++;
        if (!ok) begin
            err_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : check
    task automatic tick;
        @(posedge CLK_I);
        #1;
    endtask : tick
    task automatic push(input logic [21:0] a, input logic w, e, input logic [7:0] d);
        int n;
        {REQ_ADDR_I, REQ_WRITE_I, REQ_EXT_I, REQ_WDATA_I, REQ_VALID_I} = {a, w, e, d, 1'b1};
        for (n = 0; n < 50 && REQ_READY_O !== 1'b1; n++) tick;
        if (n == 50) begin
            check(0, "request never taken");
            close_out;
        end
        // Valid stays up so a following push needs no second assignment;
        // whoever comes next lowers it
        tick;
    endtask : push
    task automatic wait_rd(input logic [7:0] exp);
        int n;
        REQ_VALID_I = 0;
        for (n = 0; n < 100 && RD_VALID_O !== 1'b1; n++) tick;
        if (n == 100) begin
            check(0, "no read answer");
            close_out;
        end
        check(RD_DATA_O === exp, "read data");
        tick;
    endtask : wait_rd
    initial begin
        repeat (6) tick;
        check({ADDR_STROBE_N_O, DATA_STROBE_N_O, RW_O, CTL_OE_N_O} === 4'hF, "reset pins");
        check(LSO === 2'h3 && USO === 2'h3, "stretch reset");
        NRST_I = 1;
        repeat (2) tick;
        foreach (rows[i]) begin
            {DUAL_STROBE_ENABLE_I, LSI, USI, CFG_WE_I} = {rows[i].dual, rows[i].ls, rows[i].us, 1'b1};
            tick;
            CFG_WE_I = 0;
            check(LSO === rows[i].ls && USO === rows[i].us, "stretch load");
            push(rows[i].a, 1, 1, rows[i].d);
            push(rows[i].a, 0, 1, 8'h00);
            wait_rd(rows[i].d);
            check(as_len == 1 + (rows[i].a[21] ? rows[i].us : rows[i].ls), "as len");
            check(ds_len == 1, "ds len");
            check(saw_ds2 === (rows[i].dual && !rows[i].a[21]), "ds2 use");
            check(saw_ds === !(rows[i].dual && !rows[i].a[21]), "ds use");
            check(ds_rw === 1 && ds_oe === 1, "read phase pins");
            check(ds_hi === rows[i].a[21:8], "high address");
        end
        // Internal access leaves every strobe quiet
        push(22'h000077, 0, 0, 8'h00);
        REQ_VALID_I = 0;
        quiet = 1;
        repeat (10) begin
            tick;
            if (strb || !ADDR_STROBE_N_O || RD_VALID_O !== 1'b0) quiet = 0;
        end
        check(quiet, "internal quiet");
        {EXT_WAIT_ENABLE_I, slow} = 2'h3;
        push(22'h000100, 1, 1, 8'h69);
        push(22'h000100, 0, 1, 8'h00);
        wait_rd(8'h69);
        check(ds_len == 2, "wait stretch");
        check(as_len == 4, "address wait stretch");
        {EXT_WAIT_ENABLE_I, slow, BUS_FLOAT_BIT_I, DUAL_STROBE_ENABLE_I} = 4'h3;
        repeat (2) tick;
        check(CTL_OE_N_O === 1 && LOWER_BLOCK_OE_N_O === 1, "float");
        {BUS_FLOAT_BIT_I, LOWER_STROBE_AF_I} = 2'h0;
        repeat (2) tick;
        check(LOWER_BLOCK_OE_N_O === 1 && CTL_OE_N_O === 0, "af off");
        LOWER_STROBE_AF_I = 1;
        repeat (2) tick;
        check(LOWER_BLOCK_OE_N_O === 0, "af on");
        BUS_ACK_I = 1;
        for (int i = 0; i < 8; i++) push(22'h000200 + i, 0, 1, 8'h00);
        REQ_VALID_I = 0;
        tick;
        check(REQ_READY_O === 0 && ADDR_STROBE_N_O === 1, "held by ack");
        check(CTL_OE_N_O === 1, "ack float");
        BUS_ACK_I = 0;
        for (int i = 0; i < 8; i++) wait_rd(8'(i) ^ 8'hA5);
        // Reset in the middle of a cycle drops it and restores every default
        push(22'h000300, 0, 1, 8'h00);
        REQ_VALID_I = 0;
        tick;
        check(ADDR_STROBE_N_O === 0, "cycle under way");
        NRST_I = 0;
        repeat (2) tick;
        check({ADDR_STROBE_N_O, DATA_STROBE_N_O, RW_O} === 3'h7, "reset strobes");
        check(CTL_OE_N_O === 1 && AD_OE_N_O === 1, "reset released");
        check(LSO === 2'h3 && USO === 2'h3 && REQ_READY_O === 0, "reset state");
        NRST_I = 1;
        repeat (2) tick;
        check(REQ_READY_O === 1 && RD_VALID_O === 0, "after reset");
        check(ADDR_STROBE_N_O === 1, "idle after reset");
        close_out;
    end
endmodule : emb_bus_tb
